// [hdl/lps_bus_if.sv]
`timescale 1ns/1ps
interface lps_bus_if;
   logic scl;
   logic sda_o_host;
   logic sda_oe_b_host;
   logic sda_o_dev;
   logic sda_oe_b_dev;
   logic sda;
   assign sda = (!sda_oe_b_host && !sda_o_host) || (!sda_oe_b_dev && !sda_o_dev) ? 1'b0 : 1'b1;
   modport device(input scl, input sda, output sda_o_dev, output sda_oe_b_dev);
   modport host(output scl, input sda, output sda_o_host, output sda_oe_b_host);
endinterface

// [hdl/lps_host.sv]
`timescale 1ns/1ps
`include "lps_map.svh"
module lps_host (
   input wire logic i_clk,
   input wire logic i_rst_b,
   lps_bus_if.host bus,
   input wire logic i_req,
   input wire logic i_read,
   input wire logic [7:0] i_cmd,
   input wire logic [15:0] i_wdata,
   output logic o_busy,
   output logic o_done,
   output logic o_nack,
   output logic [15:0] o_rdata
);
   //------------------------------------------------------------
   // Bit-level engine: each bit is four quarter phases of SCL.
   //------------------------------------------------------------
   logic [15:0] tick, next_tick;
   logic [1:0] ph, next_ph;
   logic [5:0] bidx, next_bidx;
   logic [1:0] sda_s;
   logic busy, next_busy, rdm, next_rdm, scl, next_scl, sdo, next_sdo, nack, next_nack, done, next_done;
   logic [7:0] cmd, next_cmd;
   logic [15:0] wd, next_wd, rdat, next_rdat;
   logic [5:0] nbits;
   logic [5:0] bpos;
   logic [3:0] bi;
   logic drv_bit, is_ack_slot, master_ack;
   localparam logic [6:0] TGT_ADDR = `LPS_ADDR;
   // Frame layout: S, addr+W(9), cmd(9), then write lo(9) hi(9) or Sr, addr+R(9), lo(9), hi(9), P.
   always_comb begin
      nbits = rdm ? 6'd46 : 6'd36;
      bpos = bidx;
      bi = 4'h0;
      drv_bit = 1'b1;
      is_ack_slot = 1'b0;
      master_ack = 1'b0;
      if (bpos < 6'd9) begin
         bi = bpos[3:0];
         drv_bit = (bi < 4'd7) ? TGT_ADDR[3'(6 - bi)] : (bi == 4'd8); // [RL1] [RL5]
         is_ack_slot = (bi == 4'd8);
      end else if (bpos < 6'd18) begin
         bi = 4'(bpos - 6'd9);
         drv_bit = (bi < 4'd8) ? cmd[3'(7 - bi)] : 1'b1; // [RL2]
         is_ack_slot = (bi == 4'd8);
      end else if (!rdm) begin
         bi = 4'((bpos - 6'd18) % 9);
         drv_bit = (bi == 4'd8) ? 1'b1 : (bpos < 6'd27 ? wd[3'(7 - bi)] : wd[4'(15 - bi)]); // [RL11]
         is_ack_slot = (bi == 4'd8);
      end else if (bpos < 6'd28) begin
         bi = 4'((bpos - 6'd19) % 9);
         drv_bit = (bpos == 6'd18) ? 1'b1 : ((bi < 4'd7) ? TGT_ADDR[3'(6 - bi)] : 1'b1);
         is_ack_slot = (bpos == 6'd27);
      end else begin
         bi = 4'((bpos - 6'd28) % 9);
         master_ack = (bi == 4'd8);
         drv_bit = master_ack ? (bpos >= 6'd37) : 1'b1; // [RL5]
      end
   end

   always_comb begin
      next_tick = tick;
      next_ph = ph;
      next_bidx = bidx;
      next_busy = busy;
      next_rdm = rdm;
      next_scl = scl;
      next_sdo = sdo;
      next_nack = nack;
      next_done = 1'b0;
      next_cmd = cmd;
      next_wd = wd;
      next_rdat = rdat;
      if (!busy) begin
         if (i_req) begin
            next_busy = 1'b1;
            next_rdm = i_read; // [RL3]
            next_cmd = i_cmd;
            next_wd = i_wdata;
            next_nack = 1'b0;
            next_bidx = 6'd0;
            next_ph = 2'h0;
            next_tick = 16'h0;
            next_sdo = 1'b0; // Start.
         end
      end else if (tick == `LPS_SCL_HALF) begin
         next_tick = 16'h0;
         next_ph = ph + 2'h1;
         unique case (ph)
            2'h0: begin
               next_scl = 1'b0;
            end
            2'h1: begin
               next_sdo = (bidx == nbits) ? 1'b0 : drv_bit;
            end
            2'h2: begin
               next_scl = 1'b1;
            end
            2'h3: begin
               if (bidx == nbits) begin
                  next_sdo = 1'b1; // Stop.
                  next_busy = 1'b0;
                  next_done = 1'b1;
               end else begin
                  if (rdm && bidx == 6'd18) next_sdo = 1'b0; // Repeated start.
                  if (is_ack_slot && sda_s[1]) next_nack = 1'b1;
                  if (rdm && bidx >= 6'd28 && !master_ack) next_rdat = {rdat[14:0], sda_s[1]};
                  next_bidx = bidx + 6'd1;
               end
            end
            default: next_ph = 2'h0;
         endcase
      end else begin
         next_tick = tick + 16'h1;
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         sda_s <= 2'h3;
         tick <= 16'h0;
         ph <= 2'h0;
         bidx <= 6'd0;
         busy <= 1'b0;
         rdm <= 1'b0;
         scl <= 1'b1;
         sdo <= 1'b1;
         nack <= 1'b0;
         done <= 1'b0;
         cmd <= 8'h00;
         wd <= 16'h0000;
         rdat <= 16'h0000;
         o_busy <= 1'b0;
         o_done <= 1'b0;
         o_nack <= 1'b0;
         o_rdata <= 16'h0000;
      end else begin
         sda_s <= {sda_s[0], bus.sda};
         tick <= next_tick;
         ph <= next_ph;
         bidx <= next_bidx;
         busy <= next_busy;
         rdm <= next_rdm;
         scl <= next_scl;
         sdo <= next_sdo;
         nack <= next_nack;
         done <= next_done;
         cmd <= next_cmd;
         wd <= next_wd;
         rdat <= next_rdat;
         o_busy <= next_busy;
         o_done <= next_done;
         o_nack <= next_nack;
         // Low byte arrives first, so it ends in the upper half of the shift; swap. [RL11]
         if (next_done && next_rdm) o_rdata <= {next_rdat[7:0], next_rdat[15:8]};
      end
   end
   assign bus.scl = scl;
   assign bus.sda_o_host = 1'b0;
   assign bus.sda_oe_b_host = sdo;
endmodule

// [hdl/lps_map.svh]
//------------------------------------------------------------
// Contract
// RL1: Only target address 0x60, 7-bit addressing.
// RL2: Command codes select internal registers.
// RL3: Only word-wide write and read transfers.
// RL4: Light 16-bit; proximity 12 or 16-bit (code clips PS1 only; PS2 and PS3 stay 16-bit).
// RL5: Host drives phases; device drives acknowledge.
// RL6: Reading event flag word clears interrupt.
// RL7: Emitter duty selectable 1/40,1/80,1/160,1/320.
// RL8: Light and proximity enabled individually.
// RL9: Interrupt flags in high byte at 0x0D.
// RL10: Proximity interrupt above high, below low.
// RL11: Low byte first, high byte second.
//------------------------------------------------------------
`ifndef LPS_MAP_SVH
`define LPS_MAP_SVH
`define LPS_ADDR 7'h60
`define LPS_CMD_ALS_CONF 8'h00
`define LPS_CMD_ALS_THDH 8'h01
`define LPS_CMD_ALS_THDL 8'h02
`define LPS_CMD_PS_CONF12 8'h03
`define LPS_CMD_PS_CONF3 8'h04
`define LPS_CMD_PS_CANC 8'h05
`define LPS_CMD_PS_THDL 8'h06
`define LPS_CMD_PS_THDH 8'h07
`define LPS_CMD_PS1_DATA 8'h08
`define LPS_CMD_PS2_DATA 8'h09
`define LPS_CMD_PS3_DATA 8'h0A
`define LPS_CMD_ALS_DATA 8'h0B
`define LPS_CMD_WHITE_DATA 8'h0C
`define LPS_CMD_INT_FLAG 8'h0D
`define LPS_CMD_ID 8'h0E
`define LPS_CMD_LAST 8'h0E
`define LPS_RST_ALS_CONF 16'h0101
`define LPS_RST_PS_CONF12 16'h0001
`define LPS_RST_ZERO 16'h0000
`define LPS_BIT_SD 0
`define LPS_BIT_PS_HD 11
`define LPS_DUTY_LSB 6
`define LPS_FLAG_PS_AWAY 8
`define LPS_FLAG_PS_CLOSE 9
`define LPS_FLAG_ALS_HIGH 12
`define LPS_FLAG_ALS_LOW 13
`define LPS_PS12_MAX 16'h0FFF
`define LPS_SCL_HALF 16'd125
`endif

// [hdl/lps_pkg.sv]
package lps_pkg;
   typedef enum logic [1:0] {LPS_DUTY_40, LPS_DUTY_80, LPS_DUTY_160, LPS_DUTY_320} lps_duty_t;
   typedef enum logic [2:0] {LPS_T_IDLE, LPS_T_ADDR, LPS_T_ACK, LPS_T_RX, LPS_T_TX, LPS_T_TXACK, LPS_T_SKIP}
      lps_tstate_t;
endpackage

// [hdl/lps_target.sv]
`timescale 1ns/1ps
`include "lps_map.svh"
module lps_target (
   input wire logic i_clk,
   input wire logic i_rst_b,
   lps_bus_if.device bus,
   input wire logic [15:0] i_als_count,
   input wire logic [15:0] i_white_count,
   input wire logic [15:0] i_ps1_count,
   input wire logic [15:0] i_ps2_count,
   input wire logic [15:0] i_ps3_count,
   input wire logic i_sample,
   output logic o_int_b,
   output logic o_als_en,
   output logic o_ps_en,
   output logic [1:0] o_duty
);
   //------------------------------------------------------------
   // Pin synchronisers and edge detection
   //------------------------------------------------------------
   logic [1:0] scl_sync, sda_sync;
   logic scl_q, sda_q;
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         scl_sync <= 2'h3;
         sda_sync <= 2'h3;
         scl_q <= 1'b1;
         sda_q <= 1'b1;
      end else begin
         scl_sync <= {scl_sync[0], bus.scl};
         sda_sync <= {sda_sync[0], bus.sda};
         scl_q <= scl_sync[1];
         sda_q <= sda_sync[1];
      end
   end
   wire scl_rise = scl_sync[1] & ~scl_q;
   wire scl_fall = ~scl_sync[1] & scl_q;
   wire start_c = scl_sync[1] & sda_q & ~sda_sync[1];
   wire stop_c = scl_sync[1] & ~sda_q & sda_sync[1];

   //------------------------------------------------------------
   // Registers and measurement state
   //------------------------------------------------------------
   logic [15:0] als_conf, als_thdh, als_thdl, ps_conf12, ps_conf3, ps_canc, ps_thdl, ps_thdh, flags;
   logic [15:0] als_data, white_data, ps1_data, ps2_data, ps3_data;
   logic [15:0] next_als_conf, next_als_thdh, next_als_thdl, next_ps_conf12, next_ps_conf3;
   logic [15:0] next_ps_canc, next_ps_thdl, next_ps_thdh, next_flags;
   logic [15:0] next_als_data, next_white_data, next_ps1_data, next_ps2_data, next_ps3_data;
   // Interface state.
   lps_pkg::lps_tstate_t st, next_st;
   logic [7:0] shreg, next_shreg, cmd, next_cmd, lo_byte, next_lo_byte;
   logic [2:0] bitn, next_bitn;
   logic [1:0] nbyte, next_nbyte;
   logic rd, next_rd, sda_out, next_sda_out, int_b, next_int_b;
   // A byte is only complete after a clock rise; the first fall after a start carries no data.
   logic seen, next_seen;
   logic [15:0] ev_flags;
   logic [15:0] rword;
   logic [15:0] ps_val;

   always_comb begin
      unique case (cmd)
         `LPS_CMD_ALS_CONF: rword = als_conf;
         `LPS_CMD_ALS_THDH: rword = als_thdh;
         `LPS_CMD_ALS_THDL: rword = als_thdl;
         `LPS_CMD_PS_CONF12: rword = ps_conf12;
         `LPS_CMD_PS_CONF3: rword = ps_conf3;
         `LPS_CMD_PS_CANC: rword = ps_canc;
         `LPS_CMD_PS_THDL: rword = ps_thdl;
         `LPS_CMD_PS_THDH: rword = ps_thdh;
         `LPS_CMD_PS1_DATA: rword = ps1_data;
         `LPS_CMD_PS2_DATA: rword = ps2_data;
         `LPS_CMD_PS3_DATA: rword = ps3_data;
         `LPS_CMD_ALS_DATA: rword = als_data;
         `LPS_CMD_WHITE_DATA: rword = white_data;
         `LPS_CMD_INT_FLAG: rword = flags; // [RL9]
         `LPS_CMD_ID: rword = {8'h0, 8'h0};
         default: rword = `LPS_RST_ZERO;
      endcase
   end

   always_comb begin
      next_st = st;
      next_shreg = shreg;
      next_cmd = cmd;
      next_lo_byte = lo_byte;
      next_bitn = bitn;
      next_nbyte = nbyte;
      next_rd = rd;
      next_seen = seen;
      ev_flags = `LPS_RST_ZERO;
      next_sda_out = sda_out;
      next_als_conf = als_conf;
      next_als_thdh = als_thdh;
      next_als_thdl = als_thdl;
      next_ps_conf12 = ps_conf12;
      next_ps_conf3 = ps_conf3;
      next_ps_canc = ps_canc;
      next_ps_thdl = ps_thdl;
      next_ps_thdh = ps_thdh;
      next_flags = flags;
      next_als_data = als_data;
      next_white_data = white_data;
      next_ps1_data = ps1_data;
      next_ps2_data = ps2_data;
      next_ps3_data = ps3_data;
      // The PS1 result clips to 12 bits when the narrow resolution is chosen; PS2 and PS3 are stored unclipped.
      ps_val = (!ps_conf12[`LPS_BIT_PS_HD] && i_ps1_count > `LPS_PS12_MAX) ? `LPS_PS12_MAX : i_ps1_count; // [RL4]
      if (i_sample) begin
         if (!als_conf[`LPS_BIT_SD]) begin // [RL8]
            next_als_data = i_als_count; // [RL4]
            next_white_data = i_white_count;
            if (i_als_count > als_thdh) ev_flags[`LPS_FLAG_ALS_HIGH] = 1'b1;
            if (i_als_count < als_thdl) ev_flags[`LPS_FLAG_ALS_LOW] = 1'b1;
         end
         if (!ps_conf12[`LPS_BIT_SD]) begin // [RL8]
            next_ps1_data = ps_val;
            next_ps2_data = i_ps2_count;
            next_ps3_data = i_ps3_count;
            if (ps_val > ps_thdh) ev_flags[`LPS_FLAG_PS_CLOSE] = 1'b1; // [RL10]
            if (ps_val < ps_thdl) ev_flags[`LPS_FLAG_PS_AWAY] = 1'b1; // [RL10]
         end
      end
      if (start_c) begin
         next_st = lps_pkg::LPS_T_ADDR;
         next_bitn = 3'h0;
         next_seen = 1'b0;
         next_sda_out = 1'b1;
      end else if (stop_c) begin
         next_st = lps_pkg::LPS_T_IDLE;
         next_sda_out = 1'b1;
      end else begin
         unique case (st)
            lps_pkg::LPS_T_IDLE, lps_pkg::LPS_T_SKIP: next_sda_out = 1'b1;
            lps_pkg::LPS_T_ADDR, lps_pkg::LPS_T_RX: begin
               if (scl_rise) begin
                  next_shreg = {shreg[6:0], sda_sync[1]};
                  next_bitn = bitn + 3'h1;
                  next_seen = 1'b1;
               end
               if (scl_fall && bitn == 3'h0 && seen) begin
                  next_seen = 1'b0;
                  if (st == lps_pkg::LPS_T_ADDR) begin
                     if (shreg[7:1] == `LPS_ADDR) begin // [RL1]
                        next_rd = shreg[0];
                        next_sda_out = 1'b0; // [RL5]
                        next_st = lps_pkg::LPS_T_ACK;
                        if (!shreg[0]) next_nbyte = 2'h0;
                     end else begin
                        next_st = lps_pkg::LPS_T_SKIP;
                     end
                  end else begin
                     next_sda_out = 1'b0; // [RL5]
                     next_st = lps_pkg::LPS_T_ACK;
                     if (nbyte == 2'h0) next_cmd = shreg; // [RL2]
                     else if (nbyte == 2'h1) next_lo_byte = shreg; // [RL11]
                     else begin
                        unique case (cmd) // [RL3]
                           `LPS_CMD_ALS_CONF: next_als_conf = {shreg, lo_byte};
                           `LPS_CMD_ALS_THDH: next_als_thdh = {shreg, lo_byte};
                           `LPS_CMD_ALS_THDL: next_als_thdl = {shreg, lo_byte};
                           `LPS_CMD_PS_CONF12: next_ps_conf12 = {shreg, lo_byte};
                           `LPS_CMD_PS_CONF3: next_ps_conf3 = {shreg, lo_byte};
                           `LPS_CMD_PS_CANC: next_ps_canc = {shreg, lo_byte};
                           `LPS_CMD_PS_THDL: next_ps_thdl = {shreg, lo_byte};
                           `LPS_CMD_PS_THDH: next_ps_thdh = {shreg, lo_byte};
                           default: next_ps_canc = ps_canc;
                        endcase
                     end
                     next_nbyte = (nbyte == 2'h2) ? 2'h2 : nbyte + 2'h1;
                  end
               end
            end
            lps_pkg::LPS_T_ACK: if (scl_fall) begin
               next_bitn = 3'h0;
               if (rd) begin
                  next_st = lps_pkg::LPS_T_TX;
                  next_shreg = (nbyte == 2'h1) ? rword[7:0] : rword[15:8]; // [RL11]
                  next_sda_out = (nbyte == 2'h1) ? rword[7] : rword[15];
                  next_nbyte = (nbyte == 2'h1) ? 2'h2 : 2'h3;
               end else begin
                  next_st = lps_pkg::LPS_T_RX;
                  next_sda_out = 1'b1;
               end
            end
            lps_pkg::LPS_T_TX: if (scl_fall) begin
               next_bitn = bitn + 3'h1;
               next_shreg = {shreg[6:0], 1'b0};
               next_sda_out = (bitn == 3'h7) ? 1'b1 : shreg[6];
               if (bitn == 3'h7) begin
                  next_st = lps_pkg::LPS_T_TXACK;
                  // Flags clear when the high byte of the flag word has been shifted out.
                  if (nbyte == 2'h3 && cmd == `LPS_CMD_INT_FLAG) next_flags = `LPS_RST_ZERO; // [RL6]
               end
            end
            lps_pkg::LPS_T_TXACK: if (scl_rise) begin
               next_st = (sda_sync[1] || nbyte == 2'h3) ? lps_pkg::LPS_T_SKIP : lps_pkg::LPS_T_ACK;
            end
            default: next_st = lps_pkg::LPS_T_IDLE;
         endcase
      end
      // New events win over a clear in the same cycle.
      next_flags = next_flags | ev_flags;
      next_int_b = (next_flags == `LPS_RST_ZERO);
   end

   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         st <= lps_pkg::LPS_T_IDLE;
         shreg <= 8'h00;
         cmd <= 8'h00;
         lo_byte <= 8'h00;
         bitn <= 3'h0;
         nbyte <= 2'h0;
         rd <= 1'b0;
         seen <= 1'b0;
         sda_out <= 1'b1;
         int_b <= 1'b1;
         als_conf <= `LPS_RST_ALS_CONF;
         als_thdh <= `LPS_RST_ZERO;
         als_thdl <= `LPS_RST_ZERO;
         ps_conf12 <= `LPS_RST_PS_CONF12;
         ps_conf3 <= `LPS_RST_ZERO;
         ps_canc <= `LPS_RST_ZERO;
         ps_thdl <= `LPS_RST_ZERO;
         ps_thdh <= `LPS_RST_ZERO;
         flags <= `LPS_RST_ZERO;
         als_data <= `LPS_RST_ZERO;
         white_data <= `LPS_RST_ZERO;
         ps1_data <= `LPS_RST_ZERO;
         ps2_data <= `LPS_RST_ZERO;
         ps3_data <= `LPS_RST_ZERO;
         o_als_en <= 1'b0;
         o_ps_en <= 1'b0;
         o_duty <= 2'h0;
      end else begin
         st <= next_st;
         shreg <= next_shreg;
         cmd <= next_cmd;
         lo_byte <= next_lo_byte;
         bitn <= next_bitn;
         nbyte <= next_nbyte;
         rd <= next_rd;
         seen <= next_seen;
         sda_out <= next_sda_out;
         int_b <= next_int_b; // [RL6]
         als_conf <= next_als_conf;
         als_thdh <= next_als_thdh;
         als_thdl <= next_als_thdl;
         ps_conf12 <= next_ps_conf12;
         ps_conf3 <= next_ps_conf3;
         ps_canc <= next_ps_canc;
         ps_thdl <= next_ps_thdl;
         ps_thdh <= next_ps_thdh;
         flags <= next_flags;
         als_data <= next_als_data;
         white_data <= next_white_data;
         ps1_data <= next_ps1_data;
         ps2_data <= next_ps2_data;
         ps3_data <= next_ps3_data;
         o_als_en <= ~next_als_conf[`LPS_BIT_SD]; // [RL8]
         o_ps_en <= ~next_ps_conf12[`LPS_BIT_SD]; // [RL8]
         o_duty <= next_ps_conf12[`LPS_DUTY_LSB +: 2]; // [RL7]
      end
   end
   assign o_int_b = int_b;
   // Open drain: enable low only while pulling the line low.
   assign bus.sda_o_dev = 1'b0;
   assign bus.sda_oe_b_dev = sda_out;
endmodule

// [tb/lps_bus_chk.sv]
`timescale 1ns/1ps
module lps_bus_chk (
   input wire logic i_clk,
   input wire logic i_rst_b,
   input wire logic scl,
   input wire logic sda_o_host,
   input wire logic sda_oe_b_host,
   input wire logic sda_o_dev,
   input wire logic sda_oe_b_dev,
   input wire logic sda
);
   localparam int HI_MIN = 240;
   logic scl_q;
   logic sda_q;
   logic start_c;
   logic open_f;
   logic next_open_f;
   logic rpt;
   logic next_rpt;
   logic [7:0] rise_cnt;
   logic [7:0] next_rise_cnt;
   logic [9:0] hi_cnt;
   logic [9:0] next_hi_cnt;

   //------------------------------------------------------------
   // Frame counters
   //------------------------------------------------------------
   // The clock-rise count restarts at every start, so a repeated start opens a fresh count.
   always_comb begin
      start_c = scl && scl_q && sda_q && !sda;
      next_rise_cnt = rise_cnt;
      next_open_f = open_f;
      next_rpt = rpt;
      if (scl && scl_q && !sda_q && sda) begin
         next_open_f = 1'b0;
      end
      if (start_c) begin
         next_rise_cnt = 8'h00;
         next_rpt = open_f;
         next_open_f = 1'b1;
      end else if (scl && !scl_q && rise_cnt != 8'hFF) begin
         next_rise_cnt = rise_cnt + 8'h01;
      end
      next_hi_cnt = 10'h000;
      if (scl) begin
         next_hi_cnt = (hi_cnt == 10'h3FF) ? hi_cnt : hi_cnt + 10'h001;
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
         rise_cnt <= 8'hFF;
         hi_cnt <= 10'h3FF;
         open_f <= 1'b0;
         rpt <= 1'b0;
      end else begin
         scl_q <= scl;
         sda_q <= sda;
         rise_cnt <= next_rise_cnt;
         hi_cnt <= next_hi_cnt;
         open_f <= next_open_f;
         rpt <= next_rpt;
      end
   end

   //------------------------------------------------------------
   // Bus properties
   //------------------------------------------------------------
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_rst_b);

   sequence start_s;
      scl && $past(scl) && $past(sda) && !sda;
   endsequence

   sequence stop_s;
      scl && $past(scl) && !$past(sda) && sda;
   endsequence

   open_drain_a: assert property (!sda_o_host && !sda_o_dev)
      else $error("data line driven high by a bus party");
   idle_release_a: assert property ($rose(i_rst_b) |-> scl && sda_oe_b_host && sda_oe_b_dev)
      else $error("bus not released after reset");
   dev_stable_a: assert property (scl && $past(scl) |-> $stable(sda_oe_b_dev))
      else $error("target changed data while clock high");
   no_fight_a: assert property (scl |-> sda_oe_b_dev || sda_oe_b_host)
      else $error("both parties pull data while clock high");
   scl_high_a: assert property ($fell(scl) |-> hi_cnt >= HI_MIN)
      else $error("clock high phase too short");
   scl_low_a: assert property ($fell(scl) |-> !scl [*8] ##[1:600] scl)
      else $error("clock low phase wrong length");
   start_clock_a: assert property (start_s |-> ##[1:400] !scl)
      else $error("no clock after start");
   word_frame_a: assert property (stop_s |-> rise_cnt == 8'd37 || rise_cnt == 8'd28)
      else $error("frame does not carry a word");
   dev_ack_a: assert property ($rose(scl) && (rise_cnt == 8'h08 || (rise_cnt == 8'h11 && !rpt)) |-> !sda_oe_b_dev)
      else $error("target did not acknowledge address or command");
   host_ack_a: assert property ($rose(scl) && rpt && rise_cnt == 8'h11 |-> !sda_oe_b_host && sda_oe_b_dev)
      else $error("host did not acknowledge the low byte of a read");
endmodule

// [tb/tb_light_proximity_sensor_i2c_target.sv]
`timescale 1ns/1ps
`include "lps_map.svh"
module tb_light_proximity_sensor_i2c_target;
   logic i_clk;
   logic i_rst_b;
   logic req;
   logic rd;
   logic [7:0] cmd;
   logic [15:0] wdata;
   logic busy;
   logic done;
   logic nack;
   logic [15:0] rdata;
   logic sample;
   logic int_b;
   logic als_en;
   logic ps_en;
   logic [1:0] duty;
   logic [15:0] stat;
   int num_errors;
   int samples_checked;

   lps_bus_if bus_if();

   lps_target i_lps_target (.i_clk(i_clk), .i_rst_b(i_rst_b), .bus(bus_if), .i_als_count(16'h12AB),
      .i_white_count(16'h0F0E), .i_ps1_count(16'h0321), .i_ps2_count(16'h0432), .i_ps3_count(16'h0543),
      .i_sample(sample), .o_int_b(int_b), .o_als_en(als_en), .o_ps_en(ps_en), .o_duty(duty));

   lps_host i_lps_host (.i_clk(i_clk), .i_rst_b(i_rst_b), .bus(bus_if), .i_req(req), .i_read(rd),
      .i_cmd(cmd), .i_wdata(wdata), .o_busy(busy), .o_done(done), .o_nack(nack), .o_rdata(rdata));

   lps_bus_chk i_lps_bus_chk (.i_clk(i_clk), .i_rst_b(i_rst_b), .scl(bus_if.scl),
      .sda_o_host(bus_if.sda_o_host), .sda_oe_b_host(bus_if.sda_oe_b_host),
      .sda_o_dev(bus_if.sda_o_dev), .sda_oe_b_dev(bus_if.sda_oe_b_dev), .sda(bus_if.sda));

   assign stat = {11'h000, int_b, als_en, ps_en, duty};

   //------------------------------------------------------------
   // Tasks
   //------------------------------------------------------------
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      samples_checked++;
      if (got !== exp) begin
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
         num_errors++;
      end
   endtask

   // A read word frame runs some 24000 cycles (a write some 18600), so the wait is bounded well above that.
   task automatic xfer(input logic is_rd, input logic [7:0] code, input logic [15:0] wd);
      int n;
      @(negedge i_clk);
      req = 1'b1;
      rd = is_rd;
      cmd = code;
      wdata = wd;
      @(negedge i_clk);
      req = 1'b0;
      n = 0;
      while (done !== 1'b1 && n < 40000) begin
         @(negedge i_clk);
         n++;
      end
      if (n >= 40000) begin
         check({15'h0000, done}, 16'h0001);
      end
   endtask

   task automatic finish_test();
      if (num_errors == 0 && samples_checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   //------------------------------------------------------------
   // Clock, watchdog and tests
   //------------------------------------------------------------
   initial begin
      i_clk = 1'b0;
      forever #5 i_clk = ~i_clk;
   end

   initial begin
      repeat (98000) @(posedge i_clk);
      num_errors++;
      finish_test();
   end

   initial begin
      num_errors = 0;
      samples_checked = 0;
      i_rst_b = 1'b0;
      req = 1'b0;
      rd = 1'b0;
      cmd = 8'h00;
      wdata = 16'h0000;
      sample = 1'b0;
      repeat (2) @(negedge i_clk);
      i_rst_b = 1'b1;
      @(negedge i_clk);
      check(stat, 16'h0010);
      xfer(1'b0, `LPS_CMD_ALS_CONF, 16'h0100);
      check(stat, 16'h0018);
      check({15'h0000, nack}, 16'h0000);
      xfer(1'b0, `LPS_CMD_PS_CONF12, 16'h00C0);
      check(stat, 16'h001F);
      @(negedge i_clk);
      sample = 1'b1;
      @(negedge i_clk);
      sample = 1'b0;
      check(stat, 16'h000F);
      xfer(1'b1, `LPS_CMD_ALS_DATA, 16'h0000);
      check(rdata, 16'h12AB);
      check({15'h0000, nack}, 16'h0000);
      xfer(1'b1, `LPS_CMD_INT_FLAG, 16'h0000);
      check(rdata, 16'h1200);
      check({15'h0000, int_b}, 16'h0001);
      finish_test();
   end
endmodule
